// *** include/rocb_pkg.sv ***
// register map constants for the operating-mode configuration bank
package rocb_pkg;
    localparam logic [6:0] ADDR_BUF_DATA = 7'h00;
    localparam logic [6:0] ADDR_OPMODE = 7'h01;
    localparam logic [6:0] ADDR_DIV_HI = 7'h02;
    localparam logic [6:0] ADDR_DIV_LO = 7'h03;
    localparam logic [6:0] ADDR_REV_ID = 7'h42;
    localparam logic [6:0] ADDR_GAIN_REF = 7'h43;
    localparam logic [6:0] ADDR_GAIN_TH1 = 7'h44;
    localparam logic [6:0] ADDR_GAIN_TH2 = 7'h45;
    localparam logic [6:0] ADDR_GAIN_TH3 = 7'h46;
    localparam logic [6:0] ADDR_FAST_HOP = 7'h4b;
    localparam logic [6:0] ADDR_REF_SEL = 7'h58;
    localparam logic [6:0] ADDR_AMP_PWR = 7'h5a;
    localparam logic [6:0] ADDR_SYN_BW = 7'h5c;
    localparam logic [6:0] ADDR_QSYN_BW = 7'h5e;
    localparam logic [6:0] ADDR_CAL_TEMP = 7'h6c;
    localparam logic [6:0] ADDR_DIV_FRAC = 7'h70;

    localparam int OPM_FAMILY_BIT = 7;
    localparam int OPM_SCHEME_LSB = 5;
    localparam int OPM_SHAPE_LSB = 3;
    localparam int OPM_STATE_LSB = 0;

    localparam logic [7:0] RST_BUF_DATA = 8'h00;
    localparam logic [7:0] RST_OPMODE = 8'h01;
    localparam logic [7:0] RST_DIV_HI = 8'h1a;
    localparam logic [7:0] RST_DIV_LO = 8'h0b;
    localparam logic [7:0] RST_GAIN_REF = 8'h13;
    localparam logic [7:0] RST_GAIN_TH1 = 8'h0e;
    localparam logic [7:0] RST_GAIN_TH2 = 8'h5b;
    localparam logic [7:0] RST_GAIN_TH3 = 8'hdb;
    localparam logic [7:0] RST_FAST_HOP = 8'h2e;
    localparam logic [7:0] RST_REF_SEL = 8'h09;
    localparam logic [7:0] RST_AMP_PWR = 8'h84;
    localparam logic [7:0] RST_SYN_BW = 8'hd0;
    localparam logic [7:0] RST_QSYN_BW = 8'hd0;
    localparam logic [7:0] RST_CAL_TEMP = 8'h00;
    localparam logic [7:0] RST_DIV_FRAC = 8'h00;
    // revision code value is arbitrary
    localparam logic [7:0] REV_ID_VALUE = 8'h5a;

    localparam logic [1:0] SCHEME_FSK = 2'h0;
    localparam logic [1:0] SCHEME_OOK = 2'h1;
    localparam logic [1:0] SHAPE_RSVD_OOK = 2'h3;
    localparam logic [2:0] STATE_RSVD_LO = 3'h6;

    typedef enum logic [2:0] {
        ST_SLEEP, ST_STANDBY, ST_TX_SYNTH, ST_TX, ST_RX_SYNTH, ST_RX
    } rocb_state_e;
endpackage : rocb_pkg

// *** rtl/rocb_top.sv ***
// operating-mode configuration register bank
// Functional notes
// - bit 7 picks modem family, sleep-only
// - family write outside sleep is dropped
// - scheme 00 FSK, 01 OOK, others reserved
// - FSK shaping: none, BT1.0, BT0.5, BT0.3
// - OOK shaping: none, fc=rate, fc=2rate; 11 reserved
// - state codes sleep..receive; reset to standby
// - 16-bit divider at 0x02 high, 0x03 low
// - rate = oscillator over divider plus frac/16
// - reset reloads every register value
// - 0x42 returns read-only revision code
// - 0x6c holds last calibration temperature
// - 0x4b fast hop control, reset 0x2e
// - 0x58 reference select, reset 0x09
`timescale 1ns/1ps
module rocb_top
    import rocb_pkg::*;
(
    input wire logic I_SYS_CLK,
    input wire logic I_RST,
    input wire logic [6:0] I_ADDR,
    input wire logic [7:0] I_WDATA,
    input wire logic I_WR,
    input wire logic I_RD,
    input wire logic [7:0] I_CAL_TEMP,
    input wire logic I_CAL_TEMP_VLD,
    output logic [7:0] O_RDATA,
    output logic O_FAMILY_LONG_RANGE,
    output logic [1:0] O_MODULATION_SCHEME,
    output logic [1:0] O_PULSE_SHAPING,
    output logic O_SCHEME_VALID,
    output logic [2:0] O_STATE,
    output logic O_STATE_CHANGE,
    output logic [15:0] O_INTEGER_RATE_DIVIDER,
    output logic [3:0] O_FRACTIONAL_RATE_DIVIDER,
    output logic [7:0] O_FAST_HOP,
    output logic [7:0] O_REF_SELECT,
    output logic [7:0] O_BUF_WDATA,
    output logic O_BUF_WR
);
    logic [7:0] buf_q, div_hi_q, div_lo_q, frac_q, cal_temp_q;
    logic [7:0] gref_q, gth1_q, gth2_q, gth3_q, hop_q, refsel_q, amp_q, syn_q, qsyn_q;
    logic family_q;
    logic [1:0] scheme_q, shape_q;
    rocb_state_e state_q;
    logic state_chg_q, scheme_vld_q, buf_wr_q;
    logic [7:0] rdata_q;

    function automatic logic hit(input logic [6:0] a, input logic [6:0] b);
        hit = (a == b);
    endfunction : hit

    wire wr_opm = I_WR && hit(I_ADDR, ADDR_OPMODE);
    wire in_sleep = (state_q == ST_SLEEP);
    wire family_d = (wr_opm && in_sleep) ? I_WDATA[OPM_FAMILY_BIT] : family_q;
    wire [2:0] st_code = I_WDATA[OPM_STATE_LSB +: 3];
    wire st_ok = (st_code < STATE_RSVD_LO);
    wire [1:0] scheme_d = wr_opm ? I_WDATA[OPM_SCHEME_LSB +: 2] : scheme_q;
    wire [1:0] shape_d = wr_opm ? I_WDATA[OPM_SHAPE_LSB +: 2] : shape_q;
    // scheme and shaping legality
    wire scheme_vld_d = (scheme_d == SCHEME_FSK) ||
        ((scheme_d == SCHEME_OOK) && (shape_d != SHAPE_RSVD_OOK));
    wire [7:0] opm_rd = {family_q, scheme_q, shape_q, 3'(state_q)};

    wire [7:0] rd_mux =
        hit(I_ADDR, ADDR_BUF_DATA) ? buf_q :
        hit(I_ADDR, ADDR_OPMODE) ? opm_rd :
        hit(I_ADDR, ADDR_DIV_HI) ? div_hi_q :
        hit(I_ADDR, ADDR_DIV_LO) ? div_lo_q :
        hit(I_ADDR, ADDR_REV_ID) ? REV_ID_VALUE :
        hit(I_ADDR, ADDR_GAIN_REF) ? gref_q :
        hit(I_ADDR, ADDR_GAIN_TH1) ? gth1_q :
        hit(I_ADDR, ADDR_GAIN_TH2) ? gth2_q :
        hit(I_ADDR, ADDR_GAIN_TH3) ? gth3_q :
        hit(I_ADDR, ADDR_FAST_HOP) ? hop_q :
        hit(I_ADDR, ADDR_REF_SEL) ? refsel_q :
        hit(I_ADDR, ADDR_AMP_PWR) ? amp_q :
        hit(I_ADDR, ADDR_SYN_BW) ? syn_q :
        hit(I_ADDR, ADDR_QSYN_BW) ? qsyn_q :
        hit(I_ADDR, ADDR_CAL_TEMP) ? cal_temp_q :
        hit(I_ADDR, ADDR_DIV_FRAC) ? frac_q : 8'h00;

    // plain read-write registers, all reloaded on reset
    always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
        if (I_RST) begin
            buf_q <= RST_BUF_DATA;
            div_hi_q <= RST_DIV_HI;
            div_lo_q <= RST_DIV_LO;
            frac_q <= RST_DIV_FRAC;
            gref_q <= RST_GAIN_REF;
            gth1_q <= RST_GAIN_TH1;
            gth2_q <= RST_GAIN_TH2;
            gth3_q <= RST_GAIN_TH3;
            hop_q <= RST_FAST_HOP;
            refsel_q <= RST_REF_SEL;
            amp_q <= RST_AMP_PWR;
            syn_q <= RST_SYN_BW;
            qsyn_q <= RST_QSYN_BW;
        end else if (I_WR) begin
            if (hit(I_ADDR, ADDR_BUF_DATA)) buf_q <= I_WDATA;
            if (hit(I_ADDR, ADDR_DIV_HI)) div_hi_q <= I_WDATA;
            if (hit(I_ADDR, ADDR_DIV_LO)) div_lo_q <= I_WDATA;
            if (hit(I_ADDR, ADDR_DIV_FRAC)) frac_q <= I_WDATA;
            if (hit(I_ADDR, ADDR_GAIN_REF)) gref_q <= I_WDATA;
            if (hit(I_ADDR, ADDR_GAIN_TH1)) gth1_q <= I_WDATA;
            if (hit(I_ADDR, ADDR_GAIN_TH2)) gth2_q <= I_WDATA;
            if (hit(I_ADDR, ADDR_GAIN_TH3)) gth3_q <= I_WDATA;
            if (hit(I_ADDR, ADDR_FAST_HOP)) hop_q <= I_WDATA;
            if (hit(I_ADDR, ADDR_REF_SEL)) refsel_q <= I_WDATA;
            if (hit(I_ADDR, ADDR_AMP_PWR)) amp_q <= I_WDATA;
            if (hit(I_ADDR, ADDR_SYN_BW)) syn_q <= I_WDATA;
            if (hit(I_ADDR, ADDR_QSYN_BW)) qsyn_q <= I_WDATA;
        end
    end

    // calibration temperature capture, read-only to software
    always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
        if (I_RST) begin
            cal_temp_q <= RST_CAL_TEMP;
        end else if (I_CAL_TEMP_VLD) begin
            cal_temp_q <= I_CAL_TEMP;
        end
    end

    // operating-mode register
    always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
        if (I_RST) begin
            family_q <= RST_OPMODE[OPM_FAMILY_BIT];
            scheme_q <= RST_OPMODE[OPM_SCHEME_LSB +: 2];
            shape_q <= RST_OPMODE[OPM_SHAPE_LSB +: 2];
            state_q <= ST_STANDBY;
            state_chg_q <= 1'b0;
            scheme_vld_q <= 1'b1;
        end else begin
            family_q <= family_d;
            scheme_q <= scheme_d;
            shape_q <= shape_d;
            scheme_vld_q <= scheme_vld_d;
            state_chg_q <= wr_opm && st_ok && (st_code != 3'(state_q));
            if (wr_opm && st_ok) begin
                state_q <= rocb_state_e'(st_code);
            end
        end
    end

    // read data and registered outputs
    always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
        if (I_RST) begin
            rdata_q <= 8'h00;
            buf_wr_q <= 1'b0;
        end else begin
            rdata_q <= I_RD ? rd_mux : 8'h00;
            buf_wr_q <= I_WR && hit(I_ADDR, ADDR_BUF_DATA);
        end
    end

    assign O_RDATA = rdata_q;
    assign O_FAMILY_LONG_RANGE = family_q;
    assign O_MODULATION_SCHEME = scheme_q;
    assign O_PULSE_SHAPING = shape_q;
    assign O_SCHEME_VALID = scheme_vld_q;
    assign O_STATE = 3'(state_q);
    assign O_STATE_CHANGE = state_chg_q;
    assign O_INTEGER_RATE_DIVIDER = {div_hi_q, div_lo_q};
    assign O_FRACTIONAL_RATE_DIVIDER = frac_q[3:0];
    assign O_FAST_HOP = hop_q;
    assign O_REF_SELECT = refsel_q;
    assign O_BUF_WDATA = buf_q;
    assign O_BUF_WR = buf_wr_q;
endmodule : rocb_top

// *** tb/rocb_props.sv ***
// assertion checker on the bank ports
`timescale 1ns/1ps
module rocb_props
    import rocb_pkg::*;
(
    input wire logic I_SYS_CLK,
    input wire logic I_RST,
    input wire logic [6:0] I_ADDR,
    input wire logic [7:0] I_WDATA,
    input wire logic I_WR,
    input wire logic I_RD,
    input wire logic [7:0] O_RDATA,
    input wire logic O_FAMILY_LONG_RANGE,
    input wire logic [1:0] O_MODULATION_SCHEME,
    input wire logic [1:0] O_PULSE_SHAPING,
    input wire logic O_SCHEME_VALID,
    input wire logic [2:0] O_STATE,
    input wire logic [15:0] O_INTEGER_RATE_DIVIDER,
    input wire logic [3:0] O_FRACTIONAL_RATE_DIVIDER,
    input wire logic [7:0] O_FAST_HOP
);
    default clocking @(posedge I_SYS_CLK); endclocking
    default disable iff (I_RST);
    sequence opm_wr_s;
        I_WR && I_ADDR == ADDR_OPMODE;
    endsequence
    family_take_a: assert property (opm_wr_s ##0 O_STATE == 3'h0 |=> O_FAMILY_LONG_RANGE == ($past(I_WDATA) >= 8'h80))
        else $error("family not taken");
    family_lock_a: assert property (opm_wr_s ##0 O_STATE != 3'h0 |=> $stable(O_FAMILY_LONG_RANGE))
        else $error("family changed");
    state_take_a: assert property (opm_wr_s ##0 I_WDATA[2:1] != 2'h3 |=> {5'h00, O_STATE} == ($past(I_WDATA) & 8'h07))
        else $error("state not taken");
    state_rsvd_a: assert property (opm_wr_s ##0 I_WDATA[2:1] == 2'h3 |=> $stable(O_STATE))
        else $error("reserved state taken");
    div_high_a: assert property (I_WR && I_ADDR == ADDR_DIV_HI |=> O_INTEGER_RATE_DIVIDER[15:8] == $past(I_WDATA))
        else $error("divider high");
    frac_take_a: assert property (I_WR && I_ADDR == ADDR_DIV_FRAC |=> {4'h0, O_FRACTIONAL_RATE_DIVIDER} == ($past(I_WDATA) & 8'h0f))
        else $error("fraction");
    scheme_ok_a: assert property (O_SCHEME_VALID == (O_MODULATION_SCHEME == 2'h0 || O_MODULATION_SCHEME == 2'h1 && O_PULSE_SHAPING != 2'h3))
        else $error("scheme valid");
    hop_read_a: assert property (I_RD && I_ADDR == ADDR_FAST_HOP |=> O_RDATA == O_FAST_HOP)
        else $error("hop read");
endmodule : rocb_props
bind rocb_top rocb_props i_props (.I_SYS_CLK, .I_RST, .I_ADDR, .I_WDATA, .I_WR, .I_RD, .O_RDATA, .O_FAMILY_LONG_RANGE,
    .O_MODULATION_SCHEME, .O_PULSE_SHAPING, .O_SCHEME_VALID, .O_STATE, .O_INTEGER_RATE_DIVIDER,
    .O_FRACTIONAL_RATE_DIVIDER, .O_FAST_HOP);

// *** tb/rocb_host.sv ***
// host bus model for register cycles
`timescale 1ns/1ps
module rocb_host (
    input wire logic i_clk,
    output logic [6:0] o_addr,
    output logic [7:0] o_wdata,
    output logic o_wr,
    output logic o_rd
);
    initial {o_addr, o_wdata, o_wr, o_rd} = '0;
    task automatic cyc(input logic w, input logic [6:0] a, input logic [7:0] d);
        @(posedge i_clk);
        o_addr <= a;
        o_wdata <= d;
        o_wr <= w;
        o_rd <= !w;
        @(posedge i_clk);
        o_wr <= 1'b0;
        o_rd <= 1'b0;
        o_wdata <= ~d;
    endtask : cyc
endmodule : rocb_host

// *** tb/tb_radio_opmode_config_bank.sv ***
// self-checking bench for the bank
`timescale 1ns/1ps
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin bad_count++; $display("BAD t=%0t %h %h", $time, a, e); end end
module tb_radio_opmode_config_bank
    import rocb_pkg::*;
;
    logic clk = 1'b0, rst = 1'b1, cvld = 1'b0, rd_q = 1'b0, wr, rd, fam, sv, chg, bwr;
    logic [6:0] addr;
    logic [7:0] wd, rdata, ev, d, hop, rsel, bd, cal = 8'h00;
    logic [1:0] sch, shp;
    logic [2:0] st;
    logic [15:0] div;
    logic [3:0] frac;
    logic [31:0] seed = 32'h4d2b;
    logic [7:0] exp_q[$];
    int bad_count = 0, n_tests = 0;
    logic [15:0] rt [16] = '{16'h0000, 16'h0101, 16'h021a, 16'h030b, 16'h425a, 16'h4313, 16'h440e, 16'h455b,
        16'h46db, 16'h4b2e, 16'h5809, 16'h5a84, 16'h5cd0, 16'h5ed0, 16'h7000, 16'h7f00};
    rocb_host i_host (.i_clk(clk), .o_addr(addr), .o_wdata(wd), .o_wr(wr), .o_rd(rd));
    rocb_top i_dut (.I_SYS_CLK(clk), .I_RST(rst), .I_ADDR(addr), .I_WDATA(wd), .I_WR(wr), .I_RD(rd),
        .I_CAL_TEMP(cal), .I_CAL_TEMP_VLD(cvld), .O_RDATA(rdata), .O_FAMILY_LONG_RANGE(fam),
        .O_MODULATION_SCHEME(sch), .O_PULSE_SHAPING(shp), .O_SCHEME_VALID(sv), .O_STATE(st),
        .O_STATE_CHANGE(chg), .O_INTEGER_RATE_DIVIDER(div), .O_FRACTIONAL_RATE_DIVIDER(frac),
        .O_FAST_HOP(hop), .O_REF_SELECT(rsel), .O_BUF_WDATA(bd), .O_BUF_WR(bwr));
    initial forever #50 clk = ~clk;
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    task automatic wr_reg(input logic [6:0] a, input logic [7:0] v);
        i_host.cyc(1'b1, a, v);
        @(negedge clk);
    endtask : wr_reg
    task automatic rd_reg(input logic [6:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        i_host.cyc(1'b0, a, 8'h00);
    endtask : rd_reg
    task automatic results();
        $display("tests %0d bad %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : results
    always @(posedge clk) rd_q <= rd;
    always @(negedge clk) if (rd_q) begin
        ev = exp_q.pop_front();
        `CHK(rdata, ev)
    end
    initial begin
        repeat (5000) @(posedge clk);
        bad_count++;
        results();
    end
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        foreach (rt[i]) rd_reg(rt[i][14:8], rt[i][7:0]);
        $display("reset values done");
        for (int i = 2; i < 16; i++) begin
            seed = lfsr(seed);
            d = seed[7:0];
            wr_reg(rt[i][14:8], d);
            rd_reg(rt[i][14:8], (i == 4 || i == 15) ? rt[i][7:0] : d);
        end
        wr_reg(7'h02, 8'hab);
        wr_reg(7'h03, 8'hcd);
        `CHK(div, 16'habcd)
        wr_reg(7'h70, 8'hf7);
        `CHK(frac, 4'h7)
        wr_reg(7'h00, d);
        `CHK({bwr, bd}, {1'b1, d})
        @(posedge clk);
        cal <= d;
        cvld <= 1'b1;
        @(posedge clk);
        cvld <= 1'b0;
        rd_reg(7'h6c, d);
        $display("data registers done");
        wr_reg(7'h4b, RST_FAST_HOP);
        wr_reg(7'h01, 8'h81);
        `CHK({fam, chg, st}, 5'h01)
        wr_reg(7'h01, 8'h00);
        `CHK({chg, st}, 4'h8)
        wr_reg(7'h01, 8'h80);
        `CHK(fam, 1'b1)
        wr_reg(7'h01, 8'h06);
        `CHK({fam, st}, 4'h0)
        for (int v = 0; v < 16; v++) begin
            wr_reg(7'h01, {1'b0, v[3:0], 3'h0});
            `CHK({sv, sch, shp}, {v[3:2] == 0 || v[3:2] == 1 && v[1:0] != 3, v[3:0]})
        end
        for (int s = 5; s >= 0; s--) begin
            wr_reg(7'h01, {5'h00, s[2:0]});
            `CHK(st, s[2:0])
        end
        rst <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        rd_reg(7'h01, 8'h01);
        $display("mode register done");
        repeat (2) @(posedge clk);
        results();
    end
endmodule : tb_radio_opmode_config_bank
